/* File: hdl/sar_regs.svh */
// Timing and width constants of the converter control block
// Assumes a 50 ns system clock; times in ns, counts derived from them
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH
`define SAR_WORD_W 16
`define SAR_CLK_NS 50
`define SAR_CYC_UP(ns) (((ns) + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_CYC_DN(ns) ((ns) / `SAR_CLK_NS)
`define SAR_T_CONV_MAX_NS 1250
`define SAR_CONV_MAX_CYC `SAR_CYC_DN(`SAR_T_CONV_MAX_NS)
`define SAR_CONV_CYC_DFLT 2
`define SAR_CONV_CYC_MST_MAX 2
`define SAR_T_DATA_BUSY_NS 45
`define SAR_T_HI0_NS 12
`define SAR_T_HI1_NS 22
`define SAR_T_HI2_NS 50
`define SAR_T_HI3_NS 100
`define SAR_T_LO0_NS 7
`define SAR_T_LO1_NS 21
`define SAR_T_LO2_NS 49
`define SAR_T_LO3_NS 99
`define SAR_T_TR0_NS 3
`define SAR_T_TR1_NS 60
`define SAR_T_TR2_NS 140
`define SAR_T_TR3_NS 300
`define SAR_T_BUSY0_NS 2000
`define SAR_T_BUSY1_NS 2500
`define SAR_T_BUSY2_NS 3500
`define SAR_T_BUSY3_NS 5750
`endif

/* File: hdl/sar_pkg.sv */
// Types of the converter control block
// Assumes the constants of sar_regs.svh
package sar_pkg;
   typedef enum logic [1:0] {
      SAR_MODE_PAR = 2'h0,
      SAR_MODE_MST = 2'h1,
      SAR_MODE_SLV = 2'h2,
      SAR_MODE_RSV = 2'h3
   } sar_mode_t;

   typedef struct packed {
      sar_mode_t mode;
      logic [1:0] div_sel;
   } sar_cfg_t;

   typedef enum logic [1:0] {
      SAR_C_IDLE = 2'h0,
      SAR_C_CONV = 2'h1,
      SAR_C_PUSH = 2'h3,
      SAR_C_WAIT = 2'h2
   } sar_conv_st_t;

   typedef enum logic [1:0] {
      SAR_S_IDLE = 2'h0,
      SAR_S_SHIFT = 2'h1,
      SAR_S_TRAIL = 2'h3
   } sar_ser_st_t;
endpackage : sar_pkg

/* File: hdl/sar_buf.sv */
// Small result buffer with valid and ready on both sides
// Assumes one clock and a synchronous active-high clear
`timescale 1ns/100ps
module sar_buf #(
   parameter int W = 16,
   parameter int DEPTH = 2
) (
   // Clock and clear
   input wire logic clk_sys,
   input wire logic rst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   if (DEPTH != 2 && DEPTH != 4 && DEPTH != 8)
   begin : g_bad_depth
      $error("DEPTH must be 2, 4 or 8");
   end
   logic [W-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wr_ptr_ff;
   logic [PW-1:0] rd_ptr_ff;
   logic [PW:0] cnt_ff;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = cnt_ff != (PW+1)'(DEPTH);
   assign out_valid = cnt_ff != '0;
   assign out_data = mem_ff[rd_ptr_ff];

   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         wr_ptr_ff <= wr_ptr_ff + PW'(push);
         rd_ptr_ff <= rd_ptr_ff + PW'(pop);
         cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : sar_buf

/* File: hdl/sar_conv_ctrl.sv */
// Conversion sequencing and result read-out of the converter
// Assumes pins arrive asynchronously; the core result is on clk_sys
`timescale 1ns/100ps
`include "sar_regs.svh"
module sar_conv_ctrl #(
   parameter int CONV_CYC = `SAR_CONV_CYC_DFLT
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Host control pins
   input wire logic convert_start_n,
   input wire logic reset_req,
   input wire logic chip_select_n,
   input wire logic [1:0] mode_select,
   input wire logic [1:0] serial_clock_divide_select,
   // Serial pins
   input wire logic ext_sclk,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe,
   output logic frame_sync,
   output logic frame_sync_oe,
   output logic serial_clock,
   output logic serial_clock_oe,
   // Parallel data and status
   output logic [`SAR_WORD_W-1:0] par_data,
   output logic busy,
   // Result of the core
   input wire logic [`SAR_WORD_W-1:0] core_result
);
   localparam int WW = `SAR_WORD_W;
   localparam int BUSY_MAX_CYC = `SAR_CONV_MAX_CYC;
   localparam int PAR_DATA_MAX = BUSY_MAX_CYC - 3;
   if (CONV_CYC < 1 || CONV_CYC > `SAR_CONV_CYC_MST_MAX)
   begin : g_bad_conv
      $error("CONV_CYC too long for the master transfer budget");
   end

   // Generated clock half period in cycles, rounded up
   function automatic logic [3:0] sck_cyc(input logic [1:0] d, input logic high);
      int ns;
      ns = 0;
      unique case (d)
         2'h0: ns = high ? `SAR_T_HI0_NS : `SAR_T_LO0_NS;
         2'h1: ns = high ? `SAR_T_HI1_NS : `SAR_T_LO1_NS;
         2'h2: ns = high ? `SAR_T_HI2_NS : `SAR_T_LO2_NS;
         2'h3: ns = high ? `SAR_T_HI3_NS : `SAR_T_LO3_NS;
      endcase
      return 4'(`SAR_CYC_UP(ns));
   endfunction : sck_cyc

   // Hold of frame sync after the last clock edge, rounded up
   function automatic logic [3:0] trail_cyc(input logic [1:0] d);
      int ns;
      ns = 0;
      unique case (d)
         2'h0: ns = `SAR_T_TR0_NS;
         2'h1: ns = `SAR_T_TR1_NS;
         2'h2: ns = `SAR_T_TR2_NS;
         2'h3: ns = `SAR_T_TR3_NS;
      endcase
      return 4'(`SAR_CYC_UP(ns));
   endfunction : trail_cyc

   // Longest busy in master read-after-convert, rounded down
   function automatic logic [7:0] busy_lim(input logic [1:0] d);
      int ns;
      ns = 0;
      unique case (d)
         2'h0: ns = `SAR_T_BUSY0_NS;
         2'h1: ns = `SAR_T_BUSY1_NS;
         2'h2: ns = `SAR_T_BUSY2_NS;
         2'h3: ns = `SAR_T_BUSY3_NS;
      endcase
      return 8'(`SAR_CYC_DN(ns));
   endfunction : busy_lim

   // Pin synchronisers
   logic [8:0] s1_ff;
   logic [8:0] s2_ff;
   logic [1:0] s3_ff;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s1_ff <= 9'h050;
         s2_ff <= 9'h050;
         s3_ff <= 2'h1;
      end
      else
      begin
         s1_ff <= {serial_data_in, ext_sclk, chip_select_n, reset_req, convert_start_n,
                   mode_select, serial_clock_divide_select};
         s2_ff <= s1_ff;
         s3_ff <= {s2_ff[7], s2_ff[4]};
      end
   end

   // Decoded pin state
   sar_pkg::sar_cfg_t cfg;
   assign cfg = sar_pkg::sar_cfg_t'(s2_ff[3:0]);
   wire is_mst = cfg.mode == sar_pkg::SAR_MODE_MST;
   wire is_slv = cfg.mode == sar_pkg::SAR_MODE_SLV;
   wire is_par = !is_mst && !is_slv;
   wire cnv_fall = s3_ff[0] && !s2_ff[4];
   wire sck_rise = !s3_ff[1] && s2_ff[7];
   wire cs_off = s2_ff[6];
   wire sdi = s2_ff[8];
   wire clr = rst || s2_ff[5];

   // Conversion sequencer
   sar_pkg::sar_conv_st_t conv_st_ff;
   logic [4:0] conv_cnt_ff;
   logic busy_ff;
   logic done_ff;
   logic buf_ir;
   logic buf_ov;
   logic buf_or;
   logic [WW-1:0] buf_od;
   logic frame_end;
   wire conv_last = conv_cnt_ff == 5'(CONV_CYC - 1);
   wire par_load = buf_ov && is_par;
   wire in_wait = conv_st_ff == sar_pkg::SAR_C_WAIT;
   wire done_evt = in_wait && (is_mst ? frame_end : (is_par ? par_load : 1'b1));

   always_ff @(posedge clk_sys)
   begin
      if (clr)
      begin
         conv_st_ff <= sar_pkg::SAR_C_IDLE;
         conv_cnt_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end
      else
      begin
         done_ff <= done_evt;
         unique case (conv_st_ff)
            sar_pkg::SAR_C_IDLE:
               if (cnv_fall && buf_ir)
               begin
                  conv_st_ff <= sar_pkg::SAR_C_CONV;
                  conv_cnt_ff <= '0;
                  busy_ff <= 1'b1;
               end
            sar_pkg::SAR_C_CONV:
               if (conv_last)
               begin
                  conv_st_ff <= sar_pkg::SAR_C_PUSH;
               end
               else
               begin
                  conv_cnt_ff <= conv_cnt_ff + 5'h1;
               end
            sar_pkg::SAR_C_PUSH:
               if (buf_ir)
               begin
                  conv_st_ff <= sar_pkg::SAR_C_WAIT;
               end
            sar_pkg::SAR_C_WAIT:
               if (done_ff)
               begin
                  // Busy falls a cycle after the data or frame sync settles
                  conv_st_ff <= sar_pkg::SAR_C_IDLE;
                  busy_ff <= 1'b0;
               end
         endcase
      end
   end

   // Result buffer between the core and the read-out ports
   sar_buf #(
      .W(WW),
      .DEPTH(2)
   ) u_buf (
      .clk_sys(clk_sys),
      .rst(clr),
      .in_valid(conv_st_ff == sar_pkg::SAR_C_PUSH),
      .in_ready(buf_ir),
      .in_data(core_result),
      .out_valid(buf_ov),
      .out_ready(buf_or),
      .out_data(buf_od)
   );

   // Parallel output
   logic [WW-1:0] par_data_ff;
   logic par_upd_ff;
   always_ff @(posedge clk_sys)
   begin
      if (clr)
      begin
         par_data_ff <= '0;
         par_upd_ff <= 1'b0;
      end
      else
      begin
         par_upd_ff <= par_load;
         if (par_load)
         begin
            par_data_ff <= buf_od;
         end
      end
   end

   // Serial shifter, master framing and slave clocking
   sar_pkg::sar_ser_st_t ser_st_ff;
   logic [WW-1:0] sh_ff;
   logic [4:0] bits_ff;
   logic [3:0] ph_cnt_ff;
   logic sclk_ff;
   logic fsync_ff;
   wire ser_rdy = is_mst ? (ser_st_ff == sar_pkg::SAR_S_IDLE) : (is_slv && bits_ff == '0);
   wire ser_load = buf_ov && ser_rdy;
   wire [3:0] half_lim = sck_cyc(cfg.div_sel, sclk_ff);
   wire half_done = ph_cnt_ff == half_lim - 4'h1;
   wire trail_done = ph_cnt_ff == trail_cyc(cfg.div_sel) - 4'h1;
   wire [WW-1:0] sh_next = {sh_ff[WW-2:0], sdi};
   assign frame_end = ser_st_ff == sar_pkg::SAR_S_TRAIL && trail_done;
   assign buf_or = is_par || ser_rdy;

   always_ff @(posedge clk_sys)
   begin
      if (clr)
      begin
         ser_st_ff <= sar_pkg::SAR_S_IDLE;
         sh_ff <= '0;
         bits_ff <= '0;
         ph_cnt_ff <= '0;
         sclk_ff <= 1'b0;
         fsync_ff <= 1'b0;
      end
      else if (ser_load)
      begin
         sh_ff <= buf_od;
         bits_ff <= 5'(WW);
         ph_cnt_ff <= '0;
         sclk_ff <= 1'b0;
         if (is_mst)
         begin
            // Frame opens only once the converted word leaves the buffer
            ser_st_ff <= sar_pkg::SAR_S_SHIFT;
            fsync_ff <= 1'b1;
         end
      end
      else
      begin
         unique case (ser_st_ff)
            sar_pkg::SAR_S_IDLE:
               if (is_slv && sck_rise && bits_ff != '0)
               begin
                  sh_ff <= sh_next;
                  bits_ff <= bits_ff - 5'h1;
               end
            sar_pkg::SAR_S_SHIFT:
               if (half_done)
               begin
                  // Each half lasts its rounded-up minimum
                  ph_cnt_ff <= '0;
                  sclk_ff <= !sclk_ff;
                  if (sclk_ff)
                  begin
                     sh_ff <= sh_next;
                     bits_ff <= bits_ff - 5'h1;
                     if (bits_ff == 5'h1)
                     begin
                        ser_st_ff <= sar_pkg::SAR_S_TRAIL;
                     end
                  end
               end
               else
               begin
                  ph_cnt_ff <= ph_cnt_ff + 4'h1;
               end
            sar_pkg::SAR_S_TRAIL:
               if (trail_done)
               begin
                  ser_st_ff <= sar_pkg::SAR_S_IDLE;
                  fsync_ff <= 1'b0;
                  ph_cnt_ff <= '0;
               end
               else
               begin
                  ph_cnt_ff <= ph_cnt_ff + 4'h1;
               end
            default:
               ser_st_ff <= sar_pkg::SAR_S_IDLE;
         endcase
      end
   end

   // Pin drive
   assign serial_data_out = sh_ff[WW-1];
   assign serial_data_oe = !cs_off && !is_par;
   assign frame_sync = fsync_ff;
   assign frame_sync_oe = !cs_off && is_mst;
   assign serial_clock = sclk_ff;
   assign serial_clock_oe = !cs_off && is_mst;
   assign par_data = par_data_ff;
   assign busy = busy_ff;

   // Checks
   logic [7:0] run_ff;
   logic [7:0] busy_run_ff;
   always_ff @(posedge clk_sys)
   begin
      if (clr)
      begin
         run_ff <= '0;
         busy_run_ff <= '0;
      end
      else
      begin
         run_ff <= (run_ff == 8'hff) ? run_ff : run_ff + 8'h1;
         if (ser_load || (half_done && ser_st_ff == sar_pkg::SAR_S_SHIFT))
         begin
            run_ff <= '0;
         end
         busy_run_ff <= busy_ff ? busy_run_ff + 8'h1 : 8'h0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (clr);

   sequence seq_load_par;
      par_load ##1 par_upd_ff;
   endsequence
   sequence seq_busy_drop;
      busy_ff ##1 !busy_ff;
   endsequence

   chk_busy_short: assert property ($rose(busy_ff) && !is_mst |-> ##[1:BUSY_MAX_CYC] !busy_ff)
      else $error("busy too long outside master mode");
   chk_par_valid: assert property (cnv_fall && is_par |-> ##[1:PAR_DATA_MAX] par_upd_ff)
      else $error("parallel data late");
   chk_data_lead: assert property ($fell(busy_ff) && is_par |-> $past(par_upd_ff))
      else $error("busy fell before data settled");
   chk_sync_late: assert property ($rose(fsync_ff) |-> in_wait && $past(in_wait))
      else $error("frame sync before conversion end");
   chk_busy_frame: assert property ($fell(fsync_ff) && is_mst |-> seq_busy_drop)
      else $error("busy not dropped after frame");
   chk_sclk_high: assert property ($fell(sclk_ff) |-> $past(run_ff) + 8'h1 >= 8'(sck_cyc(cfg.div_sel, 1'b1)))
      else $error("serial clock high too short");
   chk_sclk_low: assert property ($rose(sclk_ff) |-> $past(run_ff) + 8'h1 >= 8'(sck_cyc(cfg.div_sel, 1'b0)))
      else $error("serial clock low too short");
   chk_busy_width: assert property (is_mst |-> busy_run_ff <= busy_lim(cfg.div_sel))
      else $error("busy too long in master mode");
   chk_sync_lead: assert property ($rose(sclk_ff) && bits_ff == 5'(WW) |-> $past(fsync_ff, 1))
      else $error("first clock edge before frame sync");
   chk_sync_trail: assert property ($fell(fsync_ff) |-> $past(run_ff) + 8'h1 >= 8'(trail_cyc(cfg.div_sel)))
      else $error("frame sync fell too early");
   chk_cs_release: assert property ($rose(cs_off) |->
      !serial_data_oe && !frame_sync_oe && !serial_clock_oe)
      else $error("pins not released");
   chk_cs_enable: assert property (!cs_off && is_mst |-> frame_sync_oe && serial_clock_oe)
      else $error("master pins not enabled");
   chk_par_path: assert property (par_load |-> seq_load_par)
      else $error("parallel update lost");
endmodule : sar_conv_ctrl

/* File: verif/sar_host_model.sv */
// Host side model: reads master frames and clocks slave reads
// Assumes the device pins of sar_conv_ctrl on the same clk_sys
`timescale 1ns/100ps
module sar_host_model #(
   parameter int HALF = 3
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Device serial pins
   input wire logic serial_data_out,
   input wire logic serial_data_oe,
   input wire logic frame_sync,
   input wire logic frame_sync_oe,
   input wire logic serial_clock,
   input wire logic serial_clock_oe,
   // Slave read clock
   output logic ext_sclk,
   // Bench side
   input wire logic slave_go,
   output logic [15:0] word_rx,
   output logic [4:0] bits_rx
);
   logic sclk_ff;
   logic fs_ff;
   logic [4:0] left_ff;
   int hc_ff;
   // A released data line shows the inverse of the last bit
   wire logic din = serial_data_oe ? serial_data_out : ~word_rx[0];
   wire logic mst_rise = frame_sync_oe & serial_clock_oe & frame_sync & serial_clock & ~sclk_ff;

   always_ff @(posedge clk_sys)
   begin
      sclk_ff <= serial_clock;
      fs_ff <= frame_sync;
      if (rst)
      begin
         ext_sclk <= 1'b0;
         word_rx <= 16'h0;
         bits_rx <= 5'h0;
         left_ff <= 5'h0;
         hc_ff <= 0;
      end
      else if (slave_go)
      begin
         word_rx <= 16'h0;
         bits_rx <= 5'h0;
         left_ff <= 5'h10;
         hc_ff <= 0;
      end
      else if (frame_sync & ~fs_ff)
      begin
         word_rx <= 16'h0;
         bits_rx <= 5'h0;
      end
      else if (mst_rise)
      begin
         word_rx <= {word_rx[14:0], din};
         bits_rx <= bits_rx + 5'h1;
      end
      else if (left_ff != 5'h0 || ext_sclk)
      begin
         hc_ff <= (hc_ff < HALF - 1) ? hc_ff + 1 : 0;
         if (hc_ff == HALF - 1)
         begin
            ext_sclk <= ~ext_sclk;
            if (!ext_sclk)
            begin
               word_rx <= {word_rx[14:0], din};
               bits_rx <= bits_rx + 5'h1;
               left_ff <= left_ff - 5'h1;
            end
         end
      end
   end
endmodule : sar_host_model

/* File: verif/tb_sar_conv_ctrl.sv */
// Self-checking bench of sar_conv_ctrl with a host model
// Assumes the design files under hdl/ are compiled first
`timescale 1ns/100ps
module tb_sar_conv_ctrl;
   localparam int CONV = 2;
   logic clk_sys, rst, convert_start_n, reset_req, chip_select_n, serial_data_in;
   logic [1:0] mode_select, serial_clock_divide_select;
   logic ext_sclk, serial_data_out, serial_data_oe, frame_sync, frame_sync_oe;
   logic serial_clock, serial_clock_oe, busy, slave_go;
   logic [15:0] par_data, core_result, word_rx;
   logic [4:0] bits_rx;
   int err_total, check_count;
   int hi_ns[4] = '{12, 22, 50, 100};
   int lo_ns[4] = '{7, 21, 49, 99};
   int tr_ns[4] = '{3, 60, 140, 300};
   int bs_ns[4] = '{2000, 2500, 3500, 5750};
   logic [15:0] vals[4] = '{16'ha5c3, 16'h0001, 16'h8000, 16'h3c96};

   sar_conv_ctrl #(.CONV_CYC(CONV)) DUT (.clk_sys, .rst, .convert_start_n, .reset_req,
      .chip_select_n, .mode_select, .serial_clock_divide_select, .ext_sclk, .serial_data_in,
      .serial_data_out, .serial_data_oe, .frame_sync, .frame_sync_oe, .serial_clock,
      .serial_clock_oe, .par_data, .busy, .core_result);

   sar_host_model #(.HALF(3)) HOST (.clk_sys, .rst, .serial_data_out, .serial_data_oe,
      .frame_sync, .frame_sync_oe, .serial_clock, .serial_clock_oe, .ext_sclk, .slave_go,
      .word_rx, .bits_rx);

   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic close_out();
      if (err_total == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic flag(input string what, input logic c);
      check(what, 16'h1, {15'h0, c});
   endtask : flag

   task automatic bound(input int n, input int lim);
      if (n >= lim)
      begin
         err_total++;
         $display("wrong value wait expected done seen timeout");
         close_out();
      end
   endtask : bound

   // Start strobe after an idle gap; busy is high on return unless the buffer is full
   task automatic go(input logic [15:0] v);
      core_result = v;
      repeat (10) @(negedge clk_sys);
      convert_start_n = 1'b0;
      repeat (3) @(negedge clk_sys);
      convert_start_n = 1'b1;
   endtask : go

   task automatic wait_low(input int lim);
      int n;
      for (n = 0; n < lim && busy !== 1'b0; n++)
         @(negedge clk_sys);
      bound(n, lim);
   endtask : wait_low

   task automatic par_conv(input logic [1:0] m, input logic [15:0] v);
      int n;
      int hb;
      logic [15:0] last;
      mode_select = m;
      hb = 0;
      go(v);
      for (n = 3; n < 60; n++)
      begin
         if (busy)
         begin
            hb++;
            last = par_data;
         end
         else if (hb > 0)
            break;
         @(negedge clk_sys);
      end
      bound(n, 60);
      flag("busy width", hb > 0 && hb * 50 <= 1250);
      flag("data time", n * 50 <= 1250);
      check("data before busy fall", v, last);
   endtask : par_conv

   task automatic mst_conv(input logic [1:0] d, input logic [15:0] v);
      int n, hb, run, gap, rises, bu_at, fe_at;
      logic sp, fp;
      mode_select = 2'h1;
      serial_clock_divide_select = d;
      hb = 0;
      run = 0;
      gap = 0;
      rises = 0;
      sp = 1'b0;
      fp = 1'b0;
      bu_at = -1;
      fe_at = -1;
      go(v);
      for (n = 3; n < 200; n++)
      begin
         hb += busy;
         if (busy && bu_at < 0)
            bu_at = n;
         if (frame_sync && !fp)
            flag("fsync after conv", n - bu_at >= CONV);
         if (fp && serial_clock && !sp)
         begin
            rises++;
            flag("sclk low", (run + 1) * 50 >= lo_ns[d]);
         end
         if (fp && !serial_clock && sp)
            flag("sclk high", (run + 1) * 50 >= hi_ns[d]);
         gap = (serial_clock != sp) ? 0 : gap + 1;
         if (fp && !frame_sync)
         begin
            fe_at = n;
            flag("fsync trail", gap * 50 >= tr_ns[d]);
         end
         if (!busy && bu_at >= 0)
         begin
            flag("busy after fsync", fe_at >= 0 && n - fe_at >= 1 && n - fe_at <= 2);
            break;
         end
         run = (serial_clock != sp || (frame_sync && !fp)) ? 0 : run + 1;
         sp = serial_clock;
         fp = frame_sync;
         @(negedge clk_sys);
      end
      bound(n, 200);
      flag("master busy", hb > 0 && hb * 50 <= bs_ns[d]);
      flag("sclk rises", rises == 16);
      check("frame word", v, word_rx);
   endtask : mst_conv

   task automatic cs_chk();
      mode_select = 2'h1;
      chip_select_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      flag("oe released", !(serial_data_oe | frame_sync_oe | serial_clock_oe));
      chip_select_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      flag("oe enabled", serial_data_oe & frame_sync_oe & serial_clock_oe);
      mode_select = 2'h0;
      repeat (4) @(negedge clk_sys);
      flag("parallel no drive", !(frame_sync_oe | serial_clock_oe));
   endtask : cs_chk

   task automatic slv_read(input logic [15:0] v);
      int n;
      slave_go = 1'b1;
      @(negedge clk_sys);
      slave_go = 1'b0;
      for (n = 0; n < 200 && !(bits_rx == 5'h10 && ext_sclk === 1'b0); n++)
         @(negedge clk_sys);
      bound(n, 200);
      check("slave word", v, word_rx);
   endtask : slv_read

   // Fill shifter and buffer, stall, then drain in order
   task automatic slv_fill();
      mode_select = 2'h2;
      for (int i = 0; i < 3; i++)
      begin
         go(vals[i]);
         wait_low(60);
      end
      go(vals[3]);
      repeat (40) @(negedge clk_sys);
      flag("start refused when full", !busy);
      slv_read(vals[0]);
      go(vals[3]);
      wait_low(60);
      for (int i = 1; i < 4; i++)
         slv_read(vals[i]);
   endtask : slv_fill

   task automatic pin_reset();
      mode_select = 2'h0;
      go(16'hffff);
      reset_req = 1'b1;
      repeat (4) @(negedge clk_sys);
      flag("busy cleared", !busy);
      check("data cleared", 16'h0, par_data);
      reset_req = 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask : pin_reset

   initial
   begin
      rst = 1'b1;
      {convert_start_n, reset_req, chip_select_n, serial_data_in, slave_go} = 5'h10;
      mode_select = 2'h0;
      serial_clock_divide_select = 2'h0;
      core_result = 16'h0;
      err_total = 0;
      check_count = 0;
      repeat (20) @(negedge clk_sys);
      rst = 1'b0;
      check("data after reset", 16'h0, par_data);
      flag("busy after reset", !busy);
      par_conv(2'h0, 16'h8001);
      par_conv(2'h3, 16'h7ffe);
      for (int d = 0; d < 4; d++)
         mst_conv(d[1:0], vals[d]);
      cs_chk();
      slv_fill();
      pin_reset();
      par_conv(2'h0, 16'h5aa5);
      close_out();
   end
endmodule : tb_sar_conv_ctrl
